// file: rtl/mtc_top.sv
// management transaction control: registers, clock divider and serial frame engine
//
// What this block does
// R1: control writes anytime, launch only in frame gaps
// R2: phy address field bits 28..24, reset zero
// R3: register index field bits 20..16, reset zero
// R4: access kind 15..14: 01 write, 10 read
// R5: start bit 11 written one launches transaction
// R6: start bit self clears after its write
// R7: ready flag bit 7 read only, resets one
// R8: software loads write data before write launch
// R9: software launches reads without data staging
// R10: write data register low sixteen bits, reset zero
// R11: read result stored in incoming word register
// R12: upper sixteen bits of data registers read zero
// R13: mdc equals host clock over 2*(1+divide)
// R14: port disabled while clock divide is zero
// R15: completion sets interrupt status bit zero
// R16: ready low from launch until frame fully done
// R17: software launches only while ready reads one
`timescale 1ns/1ps
`default_nettype none
module mtc_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // ethernet side: high while between frames
  input wire logic i_frame_gap,
  // interrupt
  output logic o_irq,
  // management link pins
  output logic o_mdc,
  output logic o_mdio_o,
  output logic o_mdio_oe,
  input wire logic i_mdio_i
);

  // register address match, used by every decode below
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offs);
    reg_hit = (addr == offs);
  endfunction

  // state
  mtc_pkg::mtc_state_t state, next_state;
  mtc_pkg::mtc_cmd_t cmd, next_cmd;
  logic [15:0] outgoing_word, next_outgoing_word;
  logic [15:0] incoming_word, next_incoming_word;
  logic management_port_enable, next_management_port_enable;
  logic [5:0] clk_div, next_clk_div;
  logic [5:0] div_cnt, next_div_cnt;
  logic [5:0] bit_idx, next_bit_idx;
  logic [63:0] frame, next_frame;
  logic [15:0] rx_shift, next_rx_shift;
  logic management_done_irq, next_management_done_irq;
  logic irq_enable, next_irq_enable;
  logic mdc, next_mdc;
  logic mdio_oe, next_mdio_oe;
  logic [31:0] rdata, next_rdata;

  // decoded strobes
  logic wr_ctrl;
  logic start_req;
  logic kind_ok;
  logic port_on;
  logic ready;
  logic half_tick;

  assign wr_ctrl = i_wr && reg_hit(i_addr, mtc_pkg::ADDR_CTRL);
  assign start_req = wr_ctrl && i_wdata[mtc_pkg::START_BIT]; // R5
  assign kind_ok = (i_wdata[mtc_pkg::KIND_MSB:mtc_pkg::KIND_LSB] == mtc_pkg::KIND_WRITE) ||
                   (i_wdata[mtc_pkg::KIND_MSB:mtc_pkg::KIND_LSB] == mtc_pkg::KIND_READ);
  // a zero divide would exceed the link clock limit, so it blocks the port
  assign port_on = management_port_enable && (clk_div != mtc_pkg::DIV_RESET); // R14
  assign ready = (state == mtc_pkg::ST_IDLE); // R16
  assign half_tick = (div_cnt == clk_div); // R13

  // next state of registers, divider and frame engine
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_outgoing_word = outgoing_word;
    next_incoming_word = incoming_word;
    next_management_port_enable = management_port_enable;
    next_clk_div = clk_div;
    next_div_cnt = div_cnt;
    next_bit_idx = bit_idx;
    next_frame = frame;
    next_rx_shift = rx_shift;
    next_management_done_irq = management_done_irq;
    next_irq_enable = irq_enable;
    next_mdc = mdc;
    next_mdio_oe = mdio_oe;

    // register writes; control fields are taken at any time
    if (wr_ctrl) begin // R1
      next_cmd.phy = i_wdata[mtc_pkg::PHY_MSB:mtc_pkg::PHY_LSB]; // R2
      next_cmd.regi = i_wdata[mtc_pkg::REG_MSB:mtc_pkg::REG_LSB]; // R3
      next_cmd.kind = i_wdata[mtc_pkg::KIND_MSB:mtc_pkg::KIND_LSB]; // R4
    end
    if (i_wr && reg_hit(i_addr, mtc_pkg::ADDR_WDATA)) begin
      next_outgoing_word = i_wdata[mtc_pkg::WORD_MSB:0]; // R10
    end
    if (i_wr && reg_hit(i_addr, mtc_pkg::ADDR_CFG)) begin
      next_management_port_enable = i_wdata[mtc_pkg::EN_BIT];
      next_clk_div = i_wdata[mtc_pkg::DIV_MSB:mtc_pkg::DIV_LSB];
    end
    if (i_wr && reg_hit(i_addr, mtc_pkg::ADDR_IEN)) begin
      next_irq_enable = i_wdata[mtc_pkg::IRQ_BIT];
    end
    if (i_wr && reg_hit(i_addr, mtc_pkg::ADDR_ICLR) && i_wdata[mtc_pkg::IRQ_BIT]) begin
      next_management_done_irq = 1'b0;
    end

    case (state)
      mtc_pkg::ST_IDLE: begin
        next_mdc = 1'b0;
        next_mdio_oe = 1'b0;
        next_div_cnt = '0;
        // start is acted on, never stored, so it reads back zero
        if (start_req && kind_ok) begin // R5 R6
          next_state = mtc_pkg::ST_WAIT;
        end
      end
      mtc_pkg::ST_WAIT: begin
        // the snapshot is taken at launch, in the gap between frames
        if (i_frame_gap && port_on) begin // R1 R14
          next_frame = {mtc_pkg::PREAMBLE, mtc_pkg::START_CODE, cmd.kind, cmd.phy, cmd.regi,
                        mtc_pkg::TURN_CODE, outgoing_word};
          next_bit_idx = '0;
          next_div_cnt = '0;
          next_mdio_oe = 1'b1;
          next_state = mtc_pkg::ST_SHIFT;
        end
      end
      mtc_pkg::ST_SHIFT: begin
        // link clock toggles every clk_div+1 host cycles
        // divide or kind rewritten mid-frame acts at once; the engine does not
        // guard against it, so software must wait for ready first
        if (half_tick) begin // R13
          next_div_cnt = '0;
          next_mdc = ~mdc;
          if (!mdc) begin
            // rising edge: the device samples, we sample read data
            if (cmd.kind == mtc_pkg::KIND_READ && bit_idx >= mtc_pkg::DATA_FIRST) begin
              next_rx_shift = {rx_shift[14:0], i_mdio_i};
            end
          end else if (bit_idx == mtc_pkg::LAST_BIT) begin
            next_mdio_oe = 1'b0;
            next_state = mtc_pkg::ST_DONE;
          end else begin
            // falling edge: present the next bit
            next_bit_idx = bit_idx + 6'h01;
            next_frame = {frame[62:0], 1'b0};
            // release the line from turnaround onward on reads
            if (cmd.kind == mtc_pkg::KIND_READ && (bit_idx + 6'h01) >= mtc_pkg::TURN_FIRST) begin
              next_mdio_oe = 1'b0;
            end
          end
        end else begin
          next_div_cnt = div_cnt + 6'h01;
        end
      end
      mtc_pkg::ST_DONE: begin
        if (cmd.kind == mtc_pkg::KIND_READ) begin
          next_incoming_word = rx_shift; // R11
        end
        // set beats a same-cycle clear
        next_management_done_irq = 1'b1; // R15
        next_state = mtc_pkg::ST_IDLE; // R16
      end
      default: begin
        next_state = mtc_pkg::ST_IDLE;
      end
    endcase
  end

  // read mux, answered one cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      if (reg_hit(i_addr, mtc_pkg::ADDR_CTRL)) begin
        next_rdata[mtc_pkg::PHY_MSB:mtc_pkg::PHY_LSB] = cmd.phy;
        next_rdata[mtc_pkg::REG_MSB:mtc_pkg::REG_LSB] = cmd.regi;
        next_rdata[mtc_pkg::KIND_MSB:mtc_pkg::KIND_LSB] = cmd.kind;
        next_rdata[mtc_pkg::READY_BIT] = ready; // R7
      end else if (reg_hit(i_addr, mtc_pkg::ADDR_WDATA)) begin
        next_rdata[mtc_pkg::WORD_MSB:0] = outgoing_word; // R12
      end else if (reg_hit(i_addr, mtc_pkg::ADDR_RDATA)) begin
        next_rdata[mtc_pkg::WORD_MSB:0] = incoming_word; // R12
      end else if (reg_hit(i_addr, mtc_pkg::ADDR_CFG)) begin
        next_rdata[mtc_pkg::EN_BIT] = management_port_enable;
        next_rdata[mtc_pkg::DIV_MSB:mtc_pkg::DIV_LSB] = clk_div;
      end else if (reg_hit(i_addr, mtc_pkg::ADDR_ISTAT)) begin
        next_rdata[mtc_pkg::IRQ_BIT] = management_done_irq;
      end else if (reg_hit(i_addr, mtc_pkg::ADDR_IEN)) begin
        next_rdata[mtc_pkg::IRQ_BIT] = irq_enable;
      end
    end
  end

  // all state registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= mtc_pkg::ST_IDLE;
      cmd <= '0;
      outgoing_word <= mtc_pkg::WORD_RESET;
      incoming_word <= mtc_pkg::WORD_RESET;
      management_port_enable <= 1'b0;
      clk_div <= mtc_pkg::DIV_RESET;
      div_cnt <= '0;
      bit_idx <= '0;
      frame <= '0;
      rx_shift <= '0;
      management_done_irq <= 1'b0;
      irq_enable <= 1'b0;
      mdc <= 1'b0;
      mdio_oe <= 1'b0;
      rdata <= '0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      outgoing_word <= next_outgoing_word;
      incoming_word <= next_incoming_word;
      management_port_enable <= next_management_port_enable;
      clk_div <= next_clk_div;
      div_cnt <= next_div_cnt;
      bit_idx <= next_bit_idx;
      frame <= next_frame;
      rx_shift <= next_rx_shift;
      management_done_irq <= next_management_done_irq;
      irq_enable <= next_irq_enable;
      mdc <= next_mdc;
      mdio_oe <= next_mdio_oe;
      rdata <= next_rdata;
    end
  end

  // outputs straight from flops, except o_irq which ands two flops
  assign o_rdata = rdata;
  assign o_mdc = mdc;
  assign o_mdio_o = frame[63];
  assign o_mdio_oe = mdio_oe;
  assign o_irq = management_done_irq && irq_enable;

  // checks
  // all properties sample on the host clock and sleep through reset
  gap_launch_a: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    (state == mtc_pkg::ST_WAIT && !i_frame_gap) |=> (state == mtc_pkg::ST_WAIT))
    else $error("launch outside a frame gap");
  start_launch_a: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    (ready && start_req && kind_ok) |=> (state == mtc_pkg::ST_WAIT) && !ready)
    else $error("start write did not launch");
  zero_start_a: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    (ready && !start_req) |=> ready)
    else $error("transaction launched without start");
  start_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // R6
    (i_rd && reg_hit(i_addr, mtc_pkg::ADDR_CTRL)) |=> !o_rdata[mtc_pkg::START_BIT])
    else $error("start bit read back set");
  ready_read_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    (i_rd && reg_hit(i_addr, mtc_pkg::ADDR_CTRL)) |=>
      (o_rdata[mtc_pkg::READY_BIT] == $past(ready)))
    else $error("ready flag does not match engine");
  upper_zero_a: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    (i_rd && (reg_hit(i_addr, mtc_pkg::ADDR_WDATA) || reg_hit(i_addr, mtc_pkg::ADDR_RDATA)))
      |=> (o_rdata[31:16] == 16'h0000))
    else $error("reserved data bits not zero");
  read_store_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (state == mtc_pkg::ST_DONE && cmd.kind == mtc_pkg::KIND_READ) |=>
      (incoming_word == $past(rx_shift)))
    else $error("read result not stored");
  mdc_half_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    (state == mtc_pkg::ST_SHIFT && $changed(o_mdc)) |->
      (div_cnt == 6'h00) && ($past(div_cnt) == $past(clk_div)))
    else $error("link clock half period wrong");
  port_off_a: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    (state == mtc_pkg::ST_WAIT && clk_div == mtc_pkg::DIV_RESET) |=>
      (state != mtc_pkg::ST_SHIFT))
    else $error("port ran with zero divide");
  done_irq_a: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    (state == mtc_pkg::ST_DONE) |=> management_done_irq ##0 ready)
    else $error("completion did not raise status");
  busy_frame_a: assert property (@(posedge i_clk) disable iff (i_rst) // R16
    $rose(ready) |-> ($past(state) == mtc_pkg::ST_DONE))
    else $error("ready rose before frame end");

  // a start with an unknown access kind is dropped
  kind_refuse_a: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (ready && start_req && !kind_ok) |=> ready)
    else $error("start with bad kind launched");
  // the link sits still and released whenever no frame runs
  idle_clock_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    (state == mtc_pkg::ST_IDLE || state == mtc_pkg::ST_WAIT) |->
      (!o_mdc && !o_mdio_oe))
    else $error("link active outside a frame");
  // launch needs the port enabled and a frame gap one cycle before
  launch_port_a: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    (state == mtc_pkg::ST_WAIT) ##1 (state == mtc_pkg::ST_SHIFT) |->
      ($past(management_port_enable) && $past(i_frame_gap)))
    else $error("frame started without port or gap");
  // the staged word is what the frame carries
  word_load_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    (state == mtc_pkg::ST_WAIT) ##1 (state == mtc_pkg::ST_SHIFT) |->
      (frame[mtc_pkg::WORD_MSB:0] == $past(outgoing_word)))
    else $error("frame lost the staged word");
  // staged word moves only on its own write
  wdata_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    !(i_wr && reg_hit(i_addr, mtc_pkg::ADDR_WDATA)) |=> $stable(outgoing_word))
    else $error("staged word changed without write");
  // writes drive the line all frame long
  oe_write_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    (state == mtc_pkg::ST_SHIFT && cmd.kind == mtc_pkg::KIND_WRITE) |->
      o_mdio_oe)
    else $error("write frame released the line");
  // reads hand the line over from turnaround on, or both ends would drive it
  oe_turn_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (state == mtc_pkg::ST_SHIFT && cmd.kind == mtc_pkg::KIND_READ &&
      bit_idx >= mtc_pkg::TURN_FIRST) |-> !o_mdio_oe)
    else $error("line driven during read data");
  // read result only moves at the end of a read
  read_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (state != mtc_pkg::ST_DONE) |=> $stable(incoming_word))
    else $error("read result changed mid transaction");
  // status stays until a clear write
  irq_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    (management_done_irq && !(i_wr && reg_hit(i_addr, mtc_pkg::ADDR_ICLR))) |=>
      management_done_irq)
    else $error("status dropped without clear");
  // a clear away from completion takes effect next cycle
  irq_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    (i_wr && reg_hit(i_addr, mtc_pkg::ADDR_ICLR) && i_wdata[mtc_pkg::IRQ_BIT] &&
      state != mtc_pkg::ST_DONE) |=> !management_done_irq)
    else $error("status clear ignored");

endmodule
`default_nettype wire

// file: rtl/mtc_pkg.sv
// shared constants and types for the management transaction control block
package mtc_pkg;
  // register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CFG = 12'h500;
  localparam logic [11:0] ADDR_CTRL = 12'h504;
  localparam logic [11:0] ADDR_WDATA = 12'h508;
  localparam logic [11:0] ADDR_RDATA = 12'h50C;
  localparam logic [11:0] ADDR_ISTAT = 12'h600;
  localparam logic [11:0] ADDR_IEN = 12'h640;
  localparam logic [11:0] ADDR_ICLR = 12'h660;
  // control register fields
  localparam int PHY_MSB = 28;
  localparam int PHY_LSB = 24;
  localparam int REG_MSB = 20;
  localparam int REG_LSB = 16;
  localparam int KIND_MSB = 15;
  localparam int KIND_LSB = 14;
  localparam int START_BIT = 11;
  localparam int READY_BIT = 7;
  // configuration, interrupt and data register fields
  localparam int EN_BIT = 6;
  localparam int DIV_MSB = 5;
  localparam int DIV_LSB = 0;
  localparam int IRQ_BIT = 0;
  localparam int WORD_MSB = 15;
  // access kinds
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;
  // reset values
  localparam logic [5:0] DIV_RESET = 6'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // serial frame layout, bit 0 is the first bit on the wire
  localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] TURN_CODE = 2'h2;
  localparam logic [5:0] TURN_FIRST = 6'h2E;
  localparam logic [5:0] DATA_FIRST = 6'h30;
  localparam logic [5:0] LAST_BIT = 6'h3F;
  // frame controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DONE = 2'b11
  } mtc_state_t;
  // transaction fields held in the control register
  typedef struct packed {
    logic [4:0] phy;
    logic [4:0] regi;
    logic [1:0] kind;
  } mtc_cmd_t;
endpackage

// file: bench/mtc_phy_model.sv
// behavioural phy model on the far side of the management link
`timescale 1ns/1ps
`default_nettype none
module mtc_phy_model (
  // management link
  input wire logic i_mdc,
  input wire logic i_mdio,
  // word returned on reads
  input wire logic [15:0] i_rd_word,
  // line drive back to the host
  output logic o_drive,
  output logic o_bit,
  // last frame seen and number of frames
  output logic [63:0] o_frame,
  output int o_frames
);
  int cnt;
  int ones;
  logic [63:0] sr;
  logic rd_frame;
  initial begin
    cnt = 0;
    ones = 0;
    sr = 64'h0;
    rd_frame = 1'b0;
    o_drive = 1'b0;
    o_bit = 1'b0;
    o_frame = 64'h0;
    o_frames = 0;
  end
  // sync on 32 preamble ones, then shift the frame in msb first
  always @(posedge i_mdc) begin
    if (cnt == 0) begin
      if (i_mdio) begin
        ones <= ones + 1;
      end else begin
        if (ones >= 32) begin
          cnt <= 33;
          sr <= 64'h0000_0001_FFFF_FFFE;
        end
        ones <= 0;
      end
    end else begin
      sr <= {sr[62:0], i_mdio};
      cnt <= (cnt == 63) ? 0 : cnt + 1;
      if (cnt == 63) begin
        o_frame <= {sr[62:0], i_mdio};
        o_frames <= o_frames + 1;
        ones <= 0;
      end
    end
  end
  // on reads drive turnaround low then the word; released line pulls up
  always @(negedge i_mdc) begin
    if (cnt == 47) rd_frame = (sr[12:11] == 2'h2);
    o_drive <= rd_frame && (cnt >= 47);
    o_bit <= (cnt >= 48) ? i_rd_word[63 - cnt] : 1'b0;
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench: register port, interrupt and link traffic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_frame_gap = 1'b0;
  logic [31:0] o_rdata;
  logic o_irq, o_mdc, o_mdio_o, o_mdio_oe, mdio_line, phy_drive, phy_bit;
  logic [15:0] phy_word = 16'h0000;
  logic [63:0] phy_frame;
  logic [31:0] rd_val;
  logic oe_seen = 1'b0;
  int phy_frames;
  int mismatches = 0;
  int total_checks = 0;
  int hi_run = 0;
  int hi_len = 0;
  always #50 i_clk = ~i_clk;
  // data line has a pull-up when nobody drives it
  assign mdio_line = o_mdio_oe ? o_mdio_o : (phy_drive ? phy_bit : 1'b1);
  mtc_top mtc_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_frame_gap(i_frame_gap), .o_irq(o_irq),
    .o_mdc(o_mdc), .o_mdio_o(o_mdio_o), .o_mdio_oe(o_mdio_oe), .i_mdio_i(mdio_line));
  mtc_phy_model mtc_phy_model_inst (.i_mdc(o_mdc), .i_mdio(mdio_line), .i_rd_word(phy_word),
    .o_drive(phy_drive), .o_bit(phy_bit), .o_frame(phy_frame), .o_frames(phy_frames));
  // high-phase length of the management clock, and any host drive on the line
  always @(posedge i_clk) begin
    if (o_mdio_oe) oe_seen <= 1'b1;
    if (o_mdc) begin
      hi_run <= hi_run + 1;
    end else begin
      if (hi_run != 0) hi_len <= hi_run;
      hi_run <= 0;
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
    if (what != "") chk(what, {32'h0, exp}, {32'h0, rd_val});
  endtask
  // bounded poll of the ready flag
  task automatic wait_ready;
    int n;
    n = 0;
    rd_val = 32'h0;
    while (rd_val[7] !== 1'b1 && n < 1000) begin
      rd_chk("", mtc_pkg::ADDR_CTRL, 32'h0);
      n++;
    end
    chk("ready returns", 64'h1, {63'h0, rd_val[7]});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk("ctrl reset", mtc_pkg::ADDR_CTRL, 32'h0000_0080);
    rd_chk("wdata reset", mtc_pkg::ADDR_WDATA, 32'h0);
    rd_chk("rdata reset", mtc_pkg::ADDR_RDATA, 32'h0);
    rd_chk("unmapped", 12'h7F0, 32'h0);
    $display("test reset values done");
    i_frame_gap <= 1'b1;
    reg_wr(mtc_pkg::ADDR_CFG, 32'h0000_0041);
    reg_wr(mtc_pkg::ADDR_CTRL, 32'h0000_4000);
    repeat (40) @(posedge i_clk);
    chk("frames without start", 64'h0, phy_frames);
    chk("line without start", 64'h0, oe_seen);
    rd_chk("ctrl idle", mtc_pkg::ADDR_CTRL, 32'h0000_4080);
    reg_wr(mtc_pkg::ADDR_CTRL, 32'h0000_C800);
    rd_chk("ctrl bad kind", mtc_pkg::ADDR_CTRL, 32'h0000_C080);
    chk("line bad kind", 64'h0, oe_seen);
    $display("test start bit zero done");
    // port held off by zero divide, then by no frame gap
    reg_wr(mtc_pkg::ADDR_CFG, 32'h0000_0040);
    reg_wr(mtc_pkg::ADDR_WDATA, 32'hABCD_1234);
    rd_chk("wdata", mtc_pkg::ADDR_WDATA, 32'h0000_1234);
    reg_wr(mtc_pkg::ADDR_CTRL, 32'h150A_4800);
    rd_chk("ctrl busy", mtc_pkg::ADDR_CTRL, 32'h150A_4000);
    repeat (40) @(posedge i_clk);
    chk("line with divide zero", 64'h0, oe_seen);
    i_frame_gap <= 1'b0;
    reg_wr(mtc_pkg::ADDR_CFG, 32'h0000_0041);
    repeat (40) @(posedge i_clk);
    chk("line outside gap", 64'h0, oe_seen);
    i_frame_gap <= 1'b1;
    wait_ready;
    chk("write frame", {32'hFFFF_FFFF, 2'h1, 2'h1, 5'h15, 5'h0A, 2'h2, 16'h1234}, phy_frame);
    chk("mdc high div1", 64'h2, hi_len);
    rd_chk("status", mtc_pkg::ADDR_ISTAT, 32'h1);
    chk("irq masked", 64'h0, o_irq);
    reg_wr(mtc_pkg::ADDR_IEN, 32'h1);
    #1;
    chk("irq enabled", 64'h1, o_irq);
    reg_wr(mtc_pkg::ADDR_ICLR, 32'h1);
    #1;
    chk("irq cleared", 64'h0, o_irq);
    $display("test phy write done");
    phy_word <= 16'hC35A;
    reg_wr(mtc_pkg::ADDR_CFG, 32'h0000_0042);
    reg_wr(mtc_pkg::ADDR_CTRL, 32'h031F_8800);
    wait_ready;
    rd_chk("read result", mtc_pkg::ADDR_RDATA, 32'h0000_C35A);
    chk("read frame", {32'hFFFF_FFFF, 2'h1, 2'h2, 5'h03, 5'h1F, 2'h2, 16'hC35A}, phy_frame);
    chk("mdc high div2", 64'h3, hi_len);
    chk("frame count", 64'h2, phy_frames);
    chk("irq after read", 64'h1, o_irq);
    $display("test phy read done");
    give_verdict;
  end
endmodule
`default_nettype wire
